/* File: verilog/led_gpio_strap_pin_mux.sv */
// Shared pin: status light five, general io five, and management address strap
//
// How it works
// - Light enable routes light to the pin
// - Function field picks push-pull or open output
// - Open output polarity follows sampled strap
// - Light enable clear gives general-purpose mode
// - General io: push-pull, open-drain or input
// - Strap sets default management addresses
// - Strap low: addresses 0,1,2, active high
// - Strap high: addresses 1,2,3, open output active low
// - Strap captured at reset and external release
// - Loader may replace latched strap after reset
`timescale 1ns/1ps
`include "pin_mux_cfg.svh"
module led_gpio_strap_pin_mux (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic external_reset_low,
    input wire logic pin_i,
    input wire logic light_act,
    input wire logic loader_valid,
    input wire logic loader_strap,
    input wire pin_mux_pkg::reg_req_t reg_req,
    output logic [31:0] reg_rdata,
    output logic pin_o,
    output logic pin_oe,
    output pin_mux_pkg::mgmt_addr_t mgmt_addr,
    output logic strap_valid,
    output logic strap_polarity
);

    localparam logic [2:0] SETTLE_LAST = 3'(`PM_STRAP_SETTLE_CYC - 1);

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    logic pin_s;
    logic ext_s;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    input_sync #(.RESET_VAL(1'b0)) u_pin_sync (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .async_in(pin_i),
        .sync_out(pin_s)
    );

    input_sync #(.RESET_VAL(1'b0)) u_rst_sync (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .async_in(external_reset_low),
        .sync_out(ext_s)
    );

    // ------------------------------------------------------------
    // Strap capture
    // ------------------------------------------------------------
    pin_mux_pkg::strap_state_t state_ff;
    pin_mux_pkg::strap_state_t nxt_state;
    logic [2:0] cnt_ff;
    logic [2:0] nxt_cnt;
    logic strap_ff;
    logic nxt_strap;
    logic valid_ff;
    logic nxt_valid;

    always_comb
    begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_strap = strap_ff;
        nxt_valid = valid_ff;
        unique case (state_ff)
            pin_mux_pkg::ST_HOLD:
            begin
                // Pin stays released so the strap level settles
                if (!ext_s)
                begin
                    nxt_cnt = 3'h0;
                end
                else if (cnt_ff == SETTLE_LAST)
                begin
                    nxt_state = pin_mux_pkg::ST_RUN;
                    nxt_strap = pin_s;
                    nxt_valid = 1'b1;
                end
                else
                begin
                    nxt_cnt = cnt_ff + 3'h1;
                end
            end
            pin_mux_pkg::ST_RUN:
            begin
                if (!ext_s)
                begin
                    nxt_state = pin_mux_pkg::ST_HOLD;
                    nxt_cnt = 3'h0;
                end
                else if (loader_valid)
                begin
                    nxt_strap = loader_strap;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            state_ff <= pin_mux_pkg::ST_HOLD;
            cnt_ff <= 3'h0;
            strap_ff <= `PM_RST_STRAP;
            valid_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            strap_ff <= nxt_strap;
            valid_ff <= nxt_valid;
        end
    end

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    logic light_en_ff;
    logic [1:0] light_fun_ff;
    logic gpio_od_ff;
    logic gpio_data_ff;
    logic gpio_dir_ff;
    logic [31:0] rdata_ff;
    logic nxt_light_en;
    logic [1:0] nxt_light_fun;
    logic nxt_gpio_od;
    logic nxt_gpio_data;
    logic nxt_gpio_dir;
    logic [31:0] nxt_rdata;

    always_comb
    begin
        nxt_light_en = light_en_ff;
        nxt_light_fun = light_fun_ff;
        nxt_gpio_od = gpio_od_ff;
        nxt_gpio_data = gpio_data_ff;
        nxt_gpio_dir = gpio_dir_ff;
        nxt_rdata = 32'h0;
        if (reg_req.wr)
        begin
            unique case (reg_req.addr)
                `PM_OFS_LIGHT_CFG:
                begin
                    nxt_light_en = reg_req.wdata[`PM_LIGHT_EN_BIT];
                    nxt_light_fun = reg_req.wdata[`PM_LIGHT_FUN_HI:`PM_LIGHT_FUN_LO];
                end
                `PM_OFS_GPIO_CFG:
                begin
                    nxt_gpio_od = reg_req.wdata[`PM_GPIO_OD_BIT];
                end
                `PM_OFS_GPIO_DATA_DIR:
                begin
                    nxt_gpio_data = reg_req.wdata[`PM_GPIO_DATA_BIT];
                    nxt_gpio_dir = reg_req.wdata[`PM_GPIO_DIR_BIT];
                end
                default:
                begin
                end
            endcase
        end
        if (reg_req.rd)
        begin
            unique case (reg_req.addr)
                `PM_OFS_LIGHT_CFG:
                begin
                    nxt_rdata[`PM_LIGHT_EN_BIT] = light_en_ff;
                    nxt_rdata[`PM_LIGHT_FUN_HI:`PM_LIGHT_FUN_LO] = light_fun_ff;
                end
                `PM_OFS_GPIO_CFG:
                begin
                    nxt_rdata[`PM_GPIO_OD_BIT] = gpio_od_ff;
                end
                `PM_OFS_GPIO_DATA_DIR:
                begin
                    // Output mode reads back the driven value, input mode the pin
                    nxt_rdata[`PM_GPIO_DATA_BIT] = gpio_dir_ff ? gpio_data_ff : pin_s;
                    nxt_rdata[`PM_GPIO_DIR_BIT] = gpio_dir_ff;
                end
                `PM_OFS_STRAP_STAT:
                begin
                    nxt_rdata[`PM_STAT_VPHY_LO +: 5] = mgmt_addr.vphy;
                    nxt_rdata[`PM_STAT_PORT1_LO +: 5] = mgmt_addr.port1;
                    nxt_rdata[`PM_STAT_PORT2_LO +: 5] = mgmt_addr.port2;
                    nxt_rdata[`PM_STAT_POL_BIT] = strap_ff;
                    nxt_rdata[`PM_STAT_VALID_BIT] = valid_ff;
                end
                default:
                begin
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            light_en_ff <= `PM_RST_LIGHT_EN;
            light_fun_ff <= `PM_RST_LIGHT_FUN;
            gpio_od_ff <= `PM_RST_GPIO_OD;
            gpio_data_ff <= `PM_RST_GPIO_DATA;
            gpio_dir_ff <= `PM_RST_GPIO_DIR;
            rdata_ff <= 32'h0;
        end
        else
        begin
            light_en_ff <= nxt_light_en;
            light_fun_ff <= nxt_light_fun;
            gpio_od_ff <= nxt_gpio_od;
            gpio_data_ff <= nxt_gpio_data;
            gpio_dir_ff <= nxt_gpio_dir;
            rdata_ff <= nxt_rdata;
        end
    end

    // ------------------------------------------------------------
    // Pin drive and strap-derived outputs
    // ------------------------------------------------------------
    logic o_ff;
    logic oe_ff;
    logic nxt_o;
    logic nxt_oe;
    pin_mux_pkg::mgmt_addr_t addr_ff;
    pin_mux_pkg::mgmt_addr_t nxt_addr;

    always_comb
    begin
        nxt_o = 1'b0;
        nxt_oe = 1'b0;
        if (state_ff == pin_mux_pkg::ST_RUN)
        begin
            if (light_en_ff)
            begin
                if (!light_fun_ff[0])
                begin
                    nxt_oe = 1'b1;
                    nxt_o = light_act;
                end
                else
                begin
                    // Open output drives only the active level
                    nxt_oe = light_act;
                    nxt_o = !strap_ff;
                end
            end
            else if (gpio_dir_ff)
            begin
                if (gpio_od_ff)
                begin
                    nxt_oe = !gpio_data_ff;
                    nxt_o = 1'b0;
                end
                else
                begin
                    nxt_oe = 1'b1;
                    nxt_o = gpio_data_ff;
                end
            end
        end
        if (strap_ff)
        begin
            nxt_addr.vphy = `PM_VPHY_ADDR_HIGH;
            nxt_addr.port1 = `PM_PORT1_ADDR_HIGH;
            nxt_addr.port2 = `PM_PORT2_ADDR_HIGH;
        end
        else
        begin
            nxt_addr.vphy = `PM_VPHY_ADDR_LOW;
            nxt_addr.port1 = `PM_PORT1_ADDR_LOW;
            nxt_addr.port2 = `PM_PORT2_ADDR_LOW;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            o_ff <= 1'b0;
            oe_ff <= 1'b0;
            addr_ff <= '{`PM_VPHY_ADDR_LOW, `PM_PORT1_ADDR_LOW, `PM_PORT2_ADDR_LOW};
        end
        else
        begin
            o_ff <= nxt_o;
            oe_ff <= nxt_oe;
            addr_ff <= nxt_addr;
        end
    end

    assign pin_o = o_ff;
    assign pin_oe = oe_ff;
    assign mgmt_addr = addr_ff;
    assign reg_rdata = rdata_ff;
    assign strap_valid = valid_ff;
    assign strap_polarity = strap_ff;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    wire run_w = (state_ff == pin_mux_pkg::ST_RUN);

    property p_light_pp;
        run_w && light_en_ff && !light_fun_ff[0] |=> pin_oe && pin_o == $past(light_act);
    endproperty
    a_light_pp: assert property (p_light_pp) else $error("push-pull light not driven");

    property p_light_open_high;
        run_w && light_en_ff && light_fun_ff[0] && !strap_ff
            |=> pin_o && pin_oe == $past(light_act);
    endproperty
    a_light_open_high: assert property (p_light_open_high) else $error("open light high wrong");

    property p_light_open_low;
        run_w && light_en_ff && light_fun_ff[0] && strap_ff
            |=> !pin_o && pin_oe == $past(light_act);
    endproperty
    a_light_open_low: assert property (p_light_open_low) else $error("open light low wrong");

    property p_gpio_in;
        !light_en_ff && !gpio_dir_ff |=> !pin_oe;
    endproperty
    a_gpio_in: assert property (p_gpio_in) else $error("input pin driven");

    property p_gpio_od;
        run_w && !light_en_ff && gpio_dir_ff && gpio_od_ff
            |=> !pin_o && pin_oe == !$past(gpio_data_ff);
    endproperty
    a_gpio_od: assert property (p_gpio_od) else $error("open-drain io wrong");

    property p_addr_low;
        !strap_ff |=> mgmt_addr.vphy == 5'h00 && mgmt_addr.port1 == 5'h01
            && mgmt_addr.port2 == 5'h02;
    endproperty
    a_addr_low: assert property (p_addr_low) else $error("low strap addresses wrong");

    property p_addr_high;
        strap_ff |=> mgmt_addr.vphy == 5'h01 && mgmt_addr.port1 == 5'h02
            && mgmt_addr.port2 == 5'h03;
    endproperty
    a_addr_high: assert property (p_addr_high) else $error("high strap addresses wrong");

    property p_capture;
        !run_w && ext_s && cnt_ff == SETTLE_LAST |=> run_w && strap_ff == $past(pin_s);
    endproperty
    a_capture: assert property (p_capture) else $error("strap not captured");

    property p_hold_released;
        !ext_s |=> !run_w ##1 !pin_oe;
    endproperty
    a_hold_released: assert property (p_hold_released) else $error("pin driven in reset");

    property p_loader;
        run_w && ext_s && loader_valid |=> strap_ff == $past(loader_strap);
    endproperty
    a_loader: assert property (p_loader) else $error("loader strap ignored");

    c_strap_high: cover property (!run_w ##1 run_w && strap_ff);
    c_loader: cover property (run_w && loader_valid && loader_strap != strap_ff);
    c_light_open: cover property (run_w && light_en_ff && light_fun_ff[0] && light_act);
    c_gpio_od: cover property (run_w && !light_en_ff && gpio_dir_ff && gpio_od_ff);

endmodule

/* File: verilog/pin_mux_cfg.svh */
// Constants of the shared light / general-purpose / strap pin
`ifndef PIN_MUX_CFG_SVH
`define PIN_MUX_CFG_SVH

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define PM_CLK_PERIOD_NS 40
`define PM_STRAP_SETTLE_NS 160
`define PM_STRAP_SETTLE_CYC ((`PM_STRAP_SETTLE_NS + `PM_CLK_PERIOD_NS - 1) / `PM_CLK_PERIOD_NS)

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define PM_OFS_LIGHT_CFG 8'h00
`define PM_OFS_GPIO_CFG 8'h04
`define PM_OFS_GPIO_DATA_DIR 8'h08
`define PM_OFS_STRAP_STAT 8'h0c

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define PM_LIGHT_EN_BIT 5
`define PM_LIGHT_FUN_LO 8
`define PM_LIGHT_FUN_HI 9
`define PM_GPIO_OD_BIT 5
`define PM_GPIO_DATA_BIT 5
`define PM_GPIO_DIR_BIT 21
`define PM_STAT_VPHY_LO 0
`define PM_STAT_PORT1_LO 8
`define PM_STAT_PORT2_LO 16
`define PM_STAT_POL_BIT 24
`define PM_STAT_VALID_BIT 31

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define PM_RST_LIGHT_EN 1'h0
`define PM_RST_LIGHT_FUN 2'h0
`define PM_RST_GPIO_OD 1'h0
`define PM_RST_GPIO_DATA 1'h0
`define PM_RST_GPIO_DIR 1'h0
`define PM_RST_STRAP 1'h0

// ------------------------------------------------------------
// Strap-derived management addresses
// ------------------------------------------------------------
`define PM_VPHY_ADDR_LOW 5'h00
`define PM_PORT1_ADDR_LOW 5'h01
`define PM_PORT2_ADDR_LOW 5'h02
`define PM_VPHY_ADDR_HIGH 5'h01
`define PM_PORT1_ADDR_HIGH 5'h02
`define PM_PORT2_ADDR_HIGH 5'h03

`endif

/* File: verilog/pin_mux_pkg.sv */
// Types of the shared light / general-purpose / strap pin
package pin_mux_pkg;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        logic [4:0] vphy;
        logic [4:0] port1;
        logic [4:0] port2;
    } mgmt_addr_t;

    typedef enum logic {
        ST_HOLD,
        ST_RUN
    } strap_state_t;

endpackage

/* File: verilog/input_sync.sv */
// Three-stage synchroniser with agreement filter
`timescale 1ns/1ps
module input_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic async_in,
    output logic sync_out
);

    logic s1_ff;
    logic s2_ff;
    logic s3_ff;
    logic out_ff;
    logic nxt_out;

    always_comb
    begin
        nxt_out = out_ff;
        // Accept a change only once the last two stages agree
        if (s2_ff == s3_ff)
        begin
            nxt_out = s3_ff;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            s1_ff <= RESET_VAL;
            s2_ff <= RESET_VAL;
            s3_ff <= RESET_VAL;
            out_ff <= RESET_VAL;
        end
        else
        begin
            s1_ff <= async_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            out_ff <= nxt_out;
        end
    end

    assign sync_out = out_ff;

endmodule

/* File: sim/board_pin.sv */
// Board-side model of the shared pin: external driver and pull-up
`timescale 1ns/1ps
module board_pin (
    input wire logic pin_o,
    input wire logic pin_oe,
    input wire logic ext_en,
    input wire logic ext_val,
    output logic pin_level
);
    // ------------------------------------------------------------
    // Wire resolution
    // ------------------------------------------------------------
    // The pin has a pull-up, so a released line reads high
    always_comb
    begin
        if (pin_oe)
            pin_level = pin_o;
        else if (ext_en)
            pin_level = ext_val;
        else
            pin_level = 1'b1;
    end
endmodule

/* File: sim/tb_led_gpio_strap_pin_mux.sv */
// Testbench for the shared light / general io / strap pin
`timescale 1ns/1ps
module tb_led_gpio_strap_pin_mux;
    logic ref_clk;
    logic sys_rst;
    logic external_reset_low;
    logic light_act;
    logic loader_valid;
    logic loader_strap;
    pin_mux_pkg::reg_req_t reg_req;
    logic [31:0] reg_rdata;
    logic [31:0] rv;
    logic pin_o;
    logic pin_oe;
    logic pin_level;
    logic ext_en;
    logic ext_val;
    pin_mux_pkg::mgmt_addr_t mgmt_addr;
    logic strap_valid;
    logic strap_polarity;
    int bad_count;
    int n_tests;
    int cyc;

    led_gpio_strap_pin_mux i_dut (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .external_reset_low(external_reset_low),
        .pin_i(pin_level),
        .light_act(light_act),
        .loader_valid(loader_valid),
        .loader_strap(loader_strap),
        .reg_req(reg_req),
        .reg_rdata(reg_rdata),
        .pin_o(pin_o),
        .pin_oe(pin_oe),
        .mgmt_addr(mgmt_addr),
        .strap_valid(strap_valid),
        .strap_polarity(strap_polarity)
    );

    board_pin i_board (
        .pin_o(pin_o),
        .pin_oe(pin_oe),
        .ext_en(ext_en),
        .ext_val(ext_val),
        .pin_level(pin_level)
    );

    // ------------------------------------------------------------
    // Clock and timeout
    // ------------------------------------------------------------
    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            bad_count++;
            report_and_stop();
        end
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_req.addr <= a;
        reg_req.wdata <= d;
        reg_req.wr <= 1'b1;
        @(posedge ref_clk);
        reg_req.wr <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        reg_req.addr <= a;
        reg_req.rd <= 1'b1;
        @(posedge ref_clk);
        reg_req.rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    // Expected value is {pin_oe, pin_o}
    task automatic pin_chk(input logic act, input logic [1:0] exp);
        @(posedge ref_clk);
        light_act <= act;
        repeat (2) @(posedge ref_clk);
        #1;
        check("pin_oe_o", {30'h0, pin_oe, pin_o}, {30'h0, exp});
    endtask

    // Pulse the external reset with the board holding the strap level
    task automatic ext_reset(input logic en, input logic v);
        @(posedge ref_clk);
        ext_en <= en;
        ext_val <= v;
        external_reset_low <= 1'b0;
        repeat (8) @(posedge ref_clk);
        #1;
        check("hold_oe", {31'h0, pin_oe}, 32'h0);
        @(posedge ref_clk);
        external_reset_low <= 1'b1;
        repeat (20) @(posedge ref_clk);
        ext_en <= 1'b0;
        #1;
        check("valid_kept", {31'h0, strap_valid}, 32'h1);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        sys_rst = 1'b1;
        external_reset_low = 1'b0;
        light_act = 1'b0;
        loader_valid = 1'b0;
        loader_strap = 1'b0;
        reg_req = '0;
        ext_en = 1'b1;
        ext_val = 1'b0;
        bad_count = 0;
        n_tests = 0;
        cyc = 0;
        repeat (6) @(posedge ref_clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge ref_clk);
        external_reset_low <= 1'b1;
        for (int i = 0; i < 40 && strap_valid !== 1'b1; i++)
            @(posedge ref_clk);
        ext_en <= 1'b0;
        #1;
        check("valid", {31'h0, strap_valid}, 32'h1);
        check("addr_low", {17'h0, mgmt_addr}, {17'h0, 5'h00, 5'h01, 5'h02});
        reg_rd(8'h0c, rv);
        check("status_low", rv, 32'h80020100);
        @(posedge ref_clk);
        #1;
        check("rdata_idle", reg_rdata, 32'h0);
        reg_wr(8'h0c, 32'h0);
        reg_rd(8'h0c, rv);
        check("status_ro", rv, 32'h80020100);
        reg_wr(8'h10, 32'hffffffff);
        reg_rd(8'h10, rv);
        check("unmapped", rv, 32'h0);
        // Light, push-pull then open output with strap low
        reg_wr(8'h00, 32'h20);
        pin_chk(1'b1, 2'b11);
        pin_chk(1'b0, 2'b10);
        reg_wr(8'h00, 32'h320);
        reg_rd(8'h00, rv);
        check("light_cfg", rv, 32'h320);
        pin_chk(1'b1, 2'b11);
        pin_chk(1'b0, 2'b01);
        // General io: push-pull, open-drain, input
        reg_wr(8'h00, 32'h0);
        reg_wr(8'h04, 32'h0);
        reg_wr(8'h08, 32'h200020);
        pin_chk(1'b1, 2'b11);
        reg_rd(8'h08, rv);
        check("data_dir", rv, 32'h200020);
        reg_wr(8'h08, 32'h200000);
        pin_chk(1'b1, 2'b10);
        reg_wr(8'h04, 32'h20);
        reg_rd(8'h04, rv);
        check("gpio_cfg", rv, 32'h20);
        pin_chk(1'b1, 2'b10);
        reg_wr(8'h08, 32'h200020);
        pin_chk(1'b1, 2'b00);
        reg_wr(8'h08, 32'h0);
        @(posedge ref_clk);
        ext_en <= 1'b1;
        ext_val <= 1'b1;
        repeat (8) @(posedge ref_clk);
        reg_rd(8'h08, rv);
        check("input_high", rv, 32'h20);
        check("input_oe", {31'h0, pin_oe}, 32'h0);
        @(posedge ref_clk);
        ext_val <= 1'b0;
        repeat (8) @(posedge ref_clk);
        reg_rd(8'h08, rv);
        check("input_low", rv, 32'h0);
        @(posedge ref_clk);
        ext_en <= 1'b0;
        // Loader replaces the strap with a high value
        reg_wr(8'h00, 32'h120);
        @(posedge ref_clk);
        loader_valid <= 1'b1;
        loader_strap <= 1'b1;
        @(posedge ref_clk);
        loader_valid <= 1'b0;
        loader_strap <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        check("loader_pol", {31'h0, strap_polarity}, 32'h1);
        check("addr_high", {17'h0, mgmt_addr}, {17'h0, 5'h01, 5'h02, 5'h03});
        pin_chk(1'b1, 2'b10);
        pin_chk(1'b0, 2'b00);
        // External reset recaptures low, then high from the pull-up
        ext_reset(1'b1, 1'b0);
        check("recap_low", {31'h0, strap_polarity}, 32'h0);
        check("addr_relow", {17'h0, mgmt_addr}, {17'h0, 5'h00, 5'h01, 5'h02});
        pin_chk(1'b1, 2'b11);
        ext_reset(1'b0, 1'b0);
        reg_rd(8'h0c, rv);
        check("status_high", rv, 32'h81030201);
        pin_chk(1'b1, 2'b10);
        report_and_stop();
    end
endmodule
